// file: rtl/aam_pkg.sv
// constants, opcodes and state types of the accumulator and multiplier datapath
package aam_pkg;

  // widths
  localparam int unsigned AAM_DATA_W = 16;
  localparam int unsigned AAM_ACC_W = 32;
  localparam int unsigned AAM_IMM_W = 13;

  // values after reset
  localparam logic [31:0] AAM_ACC_RST = 32'h0000_0000;
  localparam logic [15:0] AAM_WORD_RST = 16'h0000;
  localparam logic [31:0] AAM_PROD_RST = 32'h0000_0000;

  // saturation limits
  localparam logic [31:0] AAM_POS_LIMIT = 32'h7FFF_FFFF;
  localparam logic [31:0] AAM_NEG_LIMIT = 32'h8000_0000;

  // status word image: bit positions, other bits read as ones
  localparam int unsigned AAM_OV_BIT = 15;
  localparam int unsigned AAM_SAT_BIT = 14;
  localparam logic [15:0] AAM_STATUS_FILL = 16'hFFFF;

  // shift limits
  localparam logic [4:0] AAM_IN_SHIFT_MAX = 5'h10;
  localparam logic [2:0] AAM_OUT_SHIFT_ONE = 3'h1;
  localparam logic [2:0] AAM_OUT_SHIFT_FOUR = 3'h4;

  // instructions handed over by the decoder
  typedef enum logic [4:0] {
    AAM_NOP,
    AAM_LOAD_ACC,
    AAM_ADD,
    AAM_SUB,
    AAM_ADD_UNSIGNED,
    AAM_SUB_UNSIGNED,
    AAM_AND,
    AAM_OR,
    AAM_XOR,
    AAM_STORE_ACC_HIGH,
    AAM_STORE_ACC_LOW,
    AAM_SET_SATURATION,
    AAM_CLEAR_SATURATION,
    AAM_STORE_STATUS,
    AAM_LOAD_STATUS,
    AAM_LOAD_MULTIPLICAND,
    AAM_LOAD_MCAND_ADD,
    AAM_MULTIPLY,
    AAM_MULTIPLY_IMMEDIATE,
    AAM_PRODUCT_TO_ACC,
    AAM_ADD_PRODUCT,
    AAM_SUB_PRODUCT,
    AAM_BRANCH_IF_OVERFLOW,
    AAM_BRANCH_NEGATIVE,
    AAM_BRANCH_NONPOSITIVE,
    AAM_BRANCH_NONNEGATIVE,
    AAM_BRANCH_POSITIVE,
    AAM_BRANCH_NONZERO,
    AAM_BRANCH_ZERO
  } aam_op_e;

  // state of the accumulator side
  typedef struct packed {
    logic [31:0] acc;
    logic overflow_flag;
    logic saturation_enable;
    logic [15:0] data_out;
    logic data_out_valid;
    logic branch_taken;
    logic int_holdoff;
  } aam_state_s;

  // state of the multiplier side
  typedef struct packed {
    logic [15:0] mcand;
    logic [31:0] product;
  } aam_mul_s;

endpackage

// file: rtl/aam_mul_if.sv
// carrier between the accumulator datapath and its multiplier
`timescale 1ns/100ps
interface aam_mul_if;
  logic load_mcand;
  logic [15:0] mcand_data;
  logic mul_go;
  logic [15:0] mul_operand;
  logic [15:0] mcand;
  logic [31:0] product;

  modport ctrl (
    output load_mcand,
    output mcand_data,
    output mul_go,
    output mul_operand,
    input mcand,
    input product
  );

  modport unit (
    input load_mcand,
    input mcand_data,
    input mul_go,
    input mul_operand,
    output mcand,
    output product
  );
endinterface

// file: rtl/aam_mult.sv
// signed 16x16 multiplier with multiplicand and product registers
`timescale 1ns/100ps
module aam_mult
  import aam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control side
  aam_mul_if.unit mul
);

  aam_mul_s st;
  aam_mul_s next_st;
  logic signed [31:0] full_product;

  // signed product; most-negative squared gets no overflow fix and shows 32'hC000_0000
  always_comb begin
    full_product = $signed(st.mcand) * $signed(mul.mul_operand);
    if (st.mcand == 16'h8000 && mul.mul_operand == 16'h8000) begin
      full_product = 32'hC000_0000;
    end
  end

  // register updates, one instruction per edge
  always_comb begin
    next_st = st;
    if (mul.load_mcand) begin
      next_st.mcand = mul.mcand_data;
    end
    if (mul.mul_go) begin
      next_st.product = full_product;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{mcand: AAM_WORD_RST, product: AAM_PROD_RST};
    end else begin
      st <= next_st;
    end
  end

  assign mul.mcand = st.mcand;
  assign mul.product = st.product;

endmodule

// file: rtl/aam_top.sv
// accumulator, alu, output shifter, overflow handling and branch tests
`timescale 1ns/100ps
module aam_top
  import aam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // instruction from the decoder
  input wire logic op_valid,
  input aam_op_e op,
  input wire logic [4:0] in_shift,
  input wire logic [2:0] out_shift,
  input wire logic [12:0] imm,
  // data memory bus
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_out_valid,
  // status and branch results
  output logic branch_taken,
  output logic overflow_flag,
  output logic saturation_enable,
  output logic int_holdoff,
  // visible datapath registers
  output logic [31:0] acc_value,
  output logic [15:0] mcand_value,
  output logic [31:0] product_value
);

  aam_state_s st;
  aam_state_s next_st;
  aam_mul_if mul ();

  // scratch values of the combinational datapath
  logic [31:0] shifted_data;
  logic [31:0] unsigned_data;
  logic [31:0] stored_image;
  logic [31:0] alu_b;
  logic [31:0] alu_result;
  logic [31:0] logic_result;
  logic [15:0] status_word;
  logic [15:0] imm_operand;
  logic alu_sub;
  logic alu_arith;
  logic alu_ov;
  logic acc_zero;
  logic acc_neg;

  // input shifter: arithmetic left shift, shift counts above 16 clamp
  function automatic logic [31:0] in_shifter(input logic [15:0] d, input logic [4:0] n);
    logic [31:0] ext;
    logic [4:0] cnt;
    ext = {{16{d[15]}}, d};
    cnt = (n > AAM_IN_SHIFT_MAX) ? AAM_IN_SHIFT_MAX : n;
    return ext << cnt;
  endfunction

  // output shifter: only 0, 1 and 4 exist, anything else stores unshifted
  function automatic logic [31:0] out_shifter(input logic [31:0] a, input logic [2:0] n);
    logic [31:0] r;
    r = a;
    if (n == AAM_OUT_SHIFT_ONE) begin
      r = a << 1;
    end else if (n == AAM_OUT_SHIFT_FOUR) begin
      r = a << 4;
    end
    return r;
  endfunction

  // 32-bit add or subtract; top bit of the answer is the signed overflow
  function automatic logic [32:0] add_sub(input logic [31:0] a, input logic [31:0] b,
                                          input logic sub);
    logic [31:0] bb;
    logic [31:0] r;
    logic ov;
    bb = sub ? ~b : b;
    r = a + bb + {31'h0000_0000, sub};
    ov = (a[31] == bb[31]) && (r[31] != a[31]);
    return {ov, r};
  endfunction

  // immediate operand is right-justified and sign extended
  always_comb begin
    imm_operand = {{3{imm[12]}}, imm};
  end

  // data path operands
  always_comb begin
    shifted_data = in_shifter(data_in, in_shift);
    unsigned_data = {16'h0000, data_in};
    stored_image = out_shifter(st.acc, out_shift);
    acc_zero = (st.acc == AAM_ACC_RST);
    acc_neg = st.acc[31];
  end

  // status image with the flag bits in place, reserved bits as ones
  always_comb begin
    status_word = AAM_STATUS_FILL;
    status_word[AAM_OV_BIT] = st.overflow_flag;
    status_word[AAM_SAT_BIT] = st.saturation_enable;
  end

  // second alu input: product register, shifted data memory word or unshifted zero-extended data word
  always_comb begin
    alu_b = shifted_data;
    alu_sub = 1'b0;
    alu_arith = 1'b0;
    if (op_valid) begin
      case (op)
        AAM_ADD: begin
          alu_arith = 1'b1;
        end
        AAM_SUB: begin
          alu_arith = 1'b1;
          alu_sub = 1'b1;
        end
        AAM_ADD_UNSIGNED: begin
          alu_b = unsigned_data;
          alu_arith = 1'b1;
        end
        AAM_SUB_UNSIGNED: begin
          alu_b = unsigned_data;
          alu_arith = 1'b1;
          alu_sub = 1'b1;
        end
        AAM_ADD_PRODUCT, AAM_LOAD_MCAND_ADD: begin
          alu_b = mul.product;
          alu_arith = 1'b1;
        end
        AAM_SUB_PRODUCT: begin
          alu_b = mul.product;
          alu_arith = 1'b1;
          alu_sub = 1'b1;
        end
        default: begin
          alu_b = shifted_data;
        end
      endcase
    end
  end

  // adder with saturation; the accumulator is always the first operand
  always_comb begin
    logic [32:0] sum;
    sum = add_sub(st.acc, alu_b, alu_sub);
    alu_ov = alu_arith & sum[32];
    if (alu_ov && st.saturation_enable) begin
      // operands agree in sign on overflow, so the first one picks the limit
      alu_result = st.acc[31] ? AAM_NEG_LIMIT : AAM_POS_LIMIT;
    end else begin
      alu_result = sum[31:0];
    end
  end

  // logical unit: high half meets zero, so and clears it while or and xor keep it
  always_comb begin
    logic_result = st.acc;
    case (op)
      AAM_AND: begin
        logic_result = {16'h0000, st.acc[15:0] & data_in};
      end
      AAM_OR: begin
        logic_result = {st.acc[31:16], st.acc[15:0] | data_in};
      end
      AAM_XOR: begin
        logic_result = {st.acc[31:16], st.acc[15:0] ^ data_in};
      end
      default: begin
        logic_result = st.acc;
      end
    endcase
  end

  // multiplier requests go straight to the unit, taken on this edge
  always_comb begin
    mul.load_mcand = 1'b0;
    mul.mcand_data = data_in;
    mul.mul_go = 1'b0;
    mul.mul_operand = data_in;
    if (op_valid) begin
      case (op)
        AAM_LOAD_MULTIPLICAND, AAM_LOAD_MCAND_ADD: begin
          mul.load_mcand = 1'b1;
        end
        AAM_MULTIPLY: begin
          mul.mul_go = 1'b1;
        end
        AAM_MULTIPLY_IMMEDIATE: begin
          mul.mul_go = 1'b1;
          mul.mul_operand = imm_operand;
        end
        default: begin
          mul.load_mcand = 1'b0;
        end
      endcase
    end
  end

  // next state of the accumulator side
  always_comb begin
    next_st = st;
    next_st.data_out_valid = 1'b0;
    next_st.branch_taken = 1'b0;
    if (op_valid) begin
      case (op)
        AAM_LOAD_ACC: begin
          next_st.acc = shifted_data;
        end
        AAM_ADD, AAM_SUB, AAM_ADD_UNSIGNED, AAM_SUB_UNSIGNED: begin
          next_st.acc = alu_result;
        end
        AAM_ADD_PRODUCT, AAM_SUB_PRODUCT, AAM_LOAD_MCAND_ADD: begin
          next_st.acc = alu_result;
        end
        AAM_PRODUCT_TO_ACC: begin
          next_st.acc = mul.product;
        end
        // logical ops bypass the adder, so they can neither overflow nor saturate
        AAM_AND, AAM_OR, AAM_XOR: begin
          next_st.acc = logic_result;
        end
        AAM_STORE_ACC_HIGH: begin
          next_st.data_out = stored_image[31:16];
          next_st.data_out_valid = 1'b1;
        end
        AAM_STORE_ACC_LOW: begin
          next_st.data_out = stored_image[15:0];
          next_st.data_out_valid = 1'b1;
        end
        AAM_SET_SATURATION: begin
          next_st.saturation_enable = 1'b1;
        end
        AAM_CLEAR_SATURATION: begin
          next_st.saturation_enable = 1'b0;
        end
        AAM_STORE_STATUS: begin
          next_st.data_out = status_word;
          next_st.data_out_valid = 1'b1;
        end
        AAM_LOAD_STATUS: begin
          next_st.overflow_flag = data_in[AAM_OV_BIT];
          next_st.saturation_enable = data_in[AAM_SAT_BIT];
        end
        AAM_BRANCH_IF_OVERFLOW: begin
          next_st.branch_taken = st.overflow_flag;
          next_st.overflow_flag = 1'b0;
        end
        AAM_BRANCH_NEGATIVE: begin
          next_st.branch_taken = acc_neg;
        end
        AAM_BRANCH_NONPOSITIVE: begin
          next_st.branch_taken = acc_neg | acc_zero;
        end
        AAM_BRANCH_NONNEGATIVE: begin
          next_st.branch_taken = ~acc_neg;
        end
        AAM_BRANCH_POSITIVE: begin
          next_st.branch_taken = ~acc_neg & ~acc_zero;
        end
        AAM_BRANCH_NONZERO: begin
          next_st.branch_taken = ~acc_zero;
        end
        AAM_BRANCH_ZERO: begin
          next_st.branch_taken = acc_zero;
        end
        default: begin
          next_st.acc = st.acc;
        end
      endcase
      // flag is sticky; only arithmetic reaches alu_ov
      if (alu_ov) begin
        next_st.overflow_flag = 1'b1;
      end
      // hold interrupts off through the instruction after a multiply
      next_st.int_holdoff = (op == AAM_MULTIPLY) || (op == AAM_MULTIPLY_IMMEDIATE);
    end
  end

  // state register; saturation mode resets to off so it is never unknown
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{
        acc: AAM_ACC_RST,
        overflow_flag: 1'b0,
        saturation_enable: 1'b0,
        data_out: AAM_WORD_RST,
        data_out_valid: 1'b0,
        branch_taken: 1'b0,
        int_holdoff: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // multiplier with its own operand and product registers
  aam_mult u_mult (
    .clk(clk),
    .rst_b(rst_b),
    .mul(mul.unit)
  );

  // outputs straight from flip-flops
  assign data_out = st.data_out;
  assign data_out_valid = st.data_out_valid;
  assign branch_taken = st.branch_taken;
  assign overflow_flag = st.overflow_flag;
  assign saturation_enable = st.saturation_enable;
  assign int_holdoff = st.int_holdoff;
  assign acc_value = st.acc;
  assign mcand_value = mul.mcand;
  assign product_value = mul.product;

endmodule

// file: tb/aam_top_properties.sv
// port-level assertions for the accumulator and multiplier datapath
`timescale 1ns/100ps
module aam_top_properties
  import aam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // instruction side
  input wire logic op_valid,
  input aam_op_e op,
  input wire logic [2:0] out_shift,
  input wire logic [15:0] data_in,
  // results
  input wire logic [15:0] data_out,
  input wire logic data_out_valid,
  input wire logic branch_taken,
  input wire logic overflow_flag,
  input wire logic saturation_enable,
  input wire logic int_holdoff,
  input wire logic [31:0] acc_value,
  input wire logic [15:0] mcand_value,
  input wire logic [31:0] product_value
);
  logic [31:0] sh;
  logic signed [31:0] prod;
  logic br;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // reference images: shifted store word and raw signed product
  assign sh = acc_value << ((out_shift == 3'h1 || out_shift == 3'h4) ? out_shift : 3'h0);
  assign prod = $signed(mcand_value) * $signed(data_in);
  // branch condition; default doubles as the zero test
  always_comb begin
    case (op)
      AAM_BRANCH_NEGATIVE: br = acc_value[31];
      AAM_BRANCH_NONPOSITIVE: br = acc_value[31] || acc_value == 32'h0000_0000;
      AAM_BRANCH_NONNEGATIVE: br = !acc_value[31];
      AAM_BRANCH_POSITIVE: br = !acc_value[31] && acc_value != 32'h0000_0000;
      AAM_BRANCH_NONZERO: br = acc_value != 32'h0000_0000;
      default: br = acc_value == 32'h0000_0000;
    endcase
  end
  sequence s_take(aam_op_e o);
    op_valid && op == o;
  endsequence
  sequence s_mul_use(aam_op_e o);
    s_take(AAM_MULTIPLY) ##1 s_take(o);
  endsequence
  a_store_strobe: assert property (data_out_valid == $past(op_valid && op inside
    {AAM_STORE_ACC_HIGH, AAM_STORE_ACC_LOW, AAM_STORE_STATUS})) else $error("store strobe");
  a_store_high: assert property (s_take(AAM_STORE_ACC_HIGH) |=>
    data_out == $past(sh[31:16]) && $stable(acc_value)) else $error("high word");
  a_store_low: assert property (s_take(AAM_STORE_ACC_LOW) |=>
    data_out == $past(sh[15:0]) && $stable(acc_value)) else $error("low word");
  a_and_half: assert property (s_take(AAM_AND) |=>
    acc_value == {16'h0000, $past(acc_value[15:0] & data_in)}) else $error("and result");
  a_logic_noov: assert property (op_valid && op inside {AAM_AND, AAM_OR, AAM_XOR} &&
    !overflow_flag |=> !overflow_flag) else $error("logic op set overflow");
  a_ov_sticky: assert property (overflow_flag && !(op_valid && op inside
    {AAM_BRANCH_IF_OVERFLOW, AAM_LOAD_STATUS}) |=> overflow_flag) else $error("flag lost");
  a_ov_branch: assert property (s_take(AAM_BRANCH_IF_OVERFLOW) |=>
    branch_taken == $past(overflow_flag) && !overflow_flag) else $error("overflow branch");
  a_acc_branch: assert property (op_valid && op inside
    {[AAM_BRANCH_NEGATIVE:AAM_BRANCH_ZERO]} |=> branch_taken == $past(br)) else $error("branch");
  a_sat_mode: assert property (op_valid && op inside
    {AAM_SET_SATURATION, AAM_CLEAR_SATURATION} |=>
    saturation_enable == $past(op == AAM_SET_SATURATION)) else $error("saturation bit");
  a_mul_product: assert property (s_take(AAM_MULTIPLY) |=> product_value ==
    ($past(mcand_value == 16'h8000 && data_in == 16'h8000) ? 32'hC000_0000 : $past(prod)))
    else $error("product");
  a_hold_span: assert property (s_mul_use(AAM_ADD_PRODUCT) |-> int_holdoff ##1 !int_holdoff)
    else $error("interrupt hold-off");
  a_mul_to_acc: assert property (s_mul_use(AAM_PRODUCT_TO_ACC) |=>
    acc_value == $past(product_value)) else $error("product to acc");
endmodule
bind aam_top aam_top_properties u_props (.clk, .rst_b, .op_valid, .op, .out_shift, .data_in,
  .data_out, .data_out_valid, .branch_taken, .overflow_flag, .saturation_enable, .int_holdoff,
  .acc_value, .mcand_value, .product_value);

// file: tb/aam_dec_model.sv
// decoder and data memory model feeding the datapath
`timescale 1ns/100ps
module aam_dec_model
  import aam_pkg::*;
(
  // instruction and data towards the datapath
  output logic op_valid,
  output aam_op_e op,
  output logic [4:0] in_shift,
  output logic [2:0] out_shift,
  output logic [12:0] imm,
  output logic [15:0] data_in
);
  // quiet bus at time zero
  initial begin
    op_valid = 1'b0;
    op = AAM_NOP;
    data_in = 16'h0000;
  end
  // idle slots flip the data word so a stale value is never mistaken for fresh
  task automatic drive(input logic v, input aam_op_e o, input logic [15:0] d,
                       input logic [4:0] s, input logic [2:0] os, input logic [12:0] im);
    op_valid = v;
    op = o;
    in_shift = s;
    out_shift = os;
    imm = im;
    data_in = v ? d : ~data_in;
  endtask
endmodule

// file: tb/testbench.sv
// random instruction stream against a reference model of the datapath
`timescale 1ns/100ps
module testbench
  import aam_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid, data_out_valid, branch_taken, overflow_flag, saturation_enable, int_holdoff;
  aam_op_e op, o, prev;
  logic [4:0] in_shift, s;
  logic [2:0] out_shift, os;
  logic [12:0] imm, im;
  logic [15:0] data_in, data_out, mcand_value, d, m_mc, m_dout;
  logic [31:0] acc_value, product_value, m_acc, m_p;
  logic m_ov, m_sat, m_val, m_br, m_hold, v;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 31;
  always #25 clk = ~clk;
  aam_top dut (.clk, .rst_b, .op_valid, .op, .in_shift, .out_shift, .imm, .data_in, .data_out,
    .data_out_valid, .branch_taken, .overflow_flag, .saturation_enable, .int_holdoff,
    .acc_value, .mcand_value, .product_value);
  aam_dec_model dec (.op_valid, .op, .in_shift, .out_shift, .imm, .data_in);
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // the doubled most-negative case stays uncorrected
  function automatic logic [31:0] mulx(input logic [15:0] a, input logic [15:0] b);
    if (a == 16'h8000 && b == 16'h8000) return 32'hC000_0000;
    mulx = $signed(a) * $signed(b);
  endfunction
  // one instruction applied to the model state
  task automatic apply();
    logic [31:0] b, r, sh;
    logic sub, ar, ovf;
    sh = m_acc << ((os == 3'h1 || os == 3'h4) ? os : 3'h0);
    b = {{16{d[15]}}, d} << ((s > 5'h10) ? 5'h10 : s);
    ar = 1'b0;
    sub = 1'b0;
    m_val = 1'b0;
    m_br = 1'b0;
    m_hold = (o == AAM_MULTIPLY || o == AAM_MULTIPLY_IMMEDIATE);
    case (o)
      AAM_LOAD_ACC: m_acc = b;
      AAM_ADD: ar = 1'b1;
      AAM_SUB: {ar, sub} = 2'h3;
      AAM_ADD_UNSIGNED: {ar, b} = {1'b1, 16'h0000, d};
      AAM_SUB_UNSIGNED: {ar, sub, b} = {2'h3, 16'h0000, d};
      AAM_AND: m_acc = {16'h0000, m_acc[15:0] & d};
      AAM_OR: m_acc[15:0] = m_acc[15:0] | d;
      AAM_XOR: m_acc[15:0] = m_acc[15:0] ^ d;
      AAM_STORE_ACC_HIGH: {m_val, m_dout} = {1'b1, sh[31:16]};
      AAM_STORE_ACC_LOW: {m_val, m_dout} = {1'b1, sh[15:0]};
      AAM_STORE_STATUS: {m_val, m_dout} = {1'b1, m_ov, m_sat, 14'h3FFF};
      AAM_SET_SATURATION: m_sat = 1'b1;
      AAM_CLEAR_SATURATION: m_sat = 1'b0;
      AAM_LOAD_STATUS: {m_ov, m_sat} = d[15:14];
      AAM_LOAD_MULTIPLICAND: m_mc = d;
      AAM_LOAD_MCAND_ADD: {m_mc, ar, b} = {d, 1'b1, m_p};
      AAM_MULTIPLY: m_p = mulx(m_mc, d);
      AAM_MULTIPLY_IMMEDIATE: m_p = mulx(m_mc, {{3{im[12]}}, im});
      AAM_PRODUCT_TO_ACC: m_acc = m_p;
      AAM_ADD_PRODUCT: {ar, b} = {1'b1, m_p};
      AAM_SUB_PRODUCT: {ar, sub, b} = {2'h3, m_p};
      AAM_BRANCH_IF_OVERFLOW: {m_br, m_ov} = {m_ov, 1'b0};
      AAM_BRANCH_NEGATIVE: m_br = m_acc[31];
      AAM_BRANCH_NONPOSITIVE: m_br = m_acc[31] || m_acc == 32'h0000_0000;
      AAM_BRANCH_NONNEGATIVE: m_br = !m_acc[31];
      AAM_BRANCH_POSITIVE: m_br = !m_acc[31] && m_acc != 32'h0000_0000;
      AAM_BRANCH_NONZERO: m_br = m_acc != 32'h0000_0000;
      AAM_BRANCH_ZERO: m_br = m_acc == 32'h0000_0000;
      default: ;
    endcase
    // signed overflow; subtraction compares against the inverted subtrahend sign
    if (ar) begin
      r = sub ? m_acc - b : m_acc + b;
      ovf = (m_acc[31] == (b[31] ^ sub)) && (r[31] != m_acc[31]);
      m_ov = m_ov | ovf;
      m_acc = (ovf && m_sat) ? (m_acc[31] ? AAM_NEG_LIMIT : AAM_POS_LIMIT) : r;
    end
  endtask
  task automatic compare();
    chk("acc", acc_value, m_acc);
    chk("overflow", overflow_flag, m_ov);
    chk("saturation", saturation_enable, m_sat);
    chk("data_out", data_out, m_dout);
    chk("store_valid", data_out_valid, m_val);
    chk("branch", branch_taken, m_br);
    chk("holdoff", int_holdoff, m_hold);
    chk("mcand", mcand_value, m_mc);
    chk("product", product_value, m_p);
  endtask
  // reset, then one instruction per cycle with occasional idle slots
  initial begin
    {m_acc, m_p, m_mc, m_dout, m_ov, m_sat, m_val, m_br, m_hold} = '0;
    prev = AAM_NOP;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int k = 0; k < 3000; k++) begin
      compare();
      o = aam_op_e'(5'(($random(seed) & 32'h7FFF_FFFF) % 29));
      v = ($random(seed) & 7) != 0;
      if (prev == AAM_MULTIPLY || prev == AAM_MULTIPLY_IMMEDIATE) begin
        o = k[0] ? AAM_ADD_PRODUCT : AAM_PRODUCT_TO_ACC;
        v = 1'b1;
      end
      d = (($random(seed) & 3) == 0) ? 16'h8000 : 16'($random(seed));
      s = 5'($random(seed));
      os = 3'($random(seed));
      im = 13'($random(seed));
      dec.drive(v, o, d, s, os, im);
      if (v) begin
        apply();
        prev = o;
      end else begin
        {m_val, m_br} = 2'h0;
      end
      @(posedge clk);
      #1;
    end
    compare();
    summarize();
  end
endmodule
